/* File: dv/enhanced_timer_chan_b_ctrl_tb.sv */
// Bench for the timer channel B block over AHB-Lite.
// Assumes the pin model and the bound checker.
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin errors++; \
	$display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module enhanced_timer_chan_b_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import etimer_pkg::*;
	logic clk = 0, resetn = 0, hsel = 0, hwrite = 0, lvl = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2, pin_in, pin_out, pin_oe;
	logic hreadyout, hresp, capture_seen;
	wire logic hready;
	chan_mode_t amode;
	int errors = 0, n_tests = 0;
	logic [7:0] ra [7] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
	logic [7:0] ct [8] = '{8'h20, 8'h28, 8'h24, 8'h18, 8'h00, 8'h88,
		8'h98, 8'hA8};
	logic [2:0] bf [8] = '{0, 7, 7, 7, 0, 0, 7, 7};
	logic [2:0] af [8] = '{7, 7, 0, 0, 0, 0, 7, 0};
	logic re [4] = '{1, 0, 1, 0};
	logic fe [4] = '{0, 1, 1, 0};
	always #5 clk = ~clk;
	assign hready = hreadyout;
	etimer_chan_b etimer_chan_b_inst (.clk(clk), .resetn(resetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .chan_b_pin_in(pin_in),
		.chan_b_pin_out(pin_out), .chan_b_pin_oe(pin_oe),
		.chan_a_mode_sel(amode), .capture_seen(capture_seen));
	pin_model pin_model_inst (.pin_out(pin_out), .pin_oe(pin_oe), .lvl(lvl),
		.pin_in(pin_in));
	task conclude;
		$display("Checks %0d, mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : conclude
	task wt;
		int i;
		i = 0;
		@(posedge clk);
		while (hready !== 1'b1)
		begin
			i++;
			if (i > 50)
			begin
				errors++;
				conclude;
			end
			@(posedge clk);
		end
	endtask : wt
	task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		wt;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wt;
		q = hrdata;
	endtask : xfer
	task wr(input logic [7:0] a, input logic [7:0] d);
		xfer(1'b1, {24'h0, a}, {24'h0, d});
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] e);
		xfer(1'b0, {24'h0, a}, 32'h0);
		`CHK(q, {24'h0, e})
	endtask : rd
	task cap(input logic l, input logic e);
		logic s;
		s = 1'b0;
		lvl <= l;
		repeat (12)
		begin
			@(posedge clk);
			#1 if (capture_seen === 1'b1) s = 1'b1;
		end
		`CHK(s, e)
	endtask : cap
	initial
	begin
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		foreach (ra[i]) rd(ra[i], 8'h00);
		wr(8'h10, 8'hFF);
		wr(8'h14, 8'hFF);
		wr(8'h18, 8'hA5);
		wr(8'h1C, 8'hFE);
		wr(8'h24, 8'h55);
		rd(8'h10, 8'hFF);
		rd(8'h14, 8'h03);
		rd(8'h18, 8'hA5);
		rd(8'h1C, 8'h02);
		rd(8'h24, 8'h00);
		wr(8'h04, 8'h2D);
		rd(8'h04, 8'h2D);
		wr(8'h00, 8'hC0);
		repeat (2) @(posedge clk);
		`CHK(amode, MODE_TIMER)
		$display("Registers test done");
		wr(8'h20, 8'h01);
		repeat (30) @(posedge clk);
		wr(8'h20, 8'h00);
		xfer(1'b0, 32'h08, 32'h0);
		`CHK(q[7:0] > 8'd20, 1'b1)
		repeat (5) @(posedge clk);
		rd(8'h08, q[7:0]);
		rd(8'h0C, 8'h00);
		wr(8'h20, 8'h01);
		repeat (2) @(posedge clk);
		xfer(1'b0, 32'h08, 32'h0);
		`CHK(q[7:0] < 8'd8, 1'b1)
		$display("Counter test done");
		wr(8'h10, 8'h14);
		wr(8'h14, 8'h00);
		wr(8'h18, 8'h14);
		wr(8'h1C, 8'h00);
		foreach (ct[i])
		begin
			wr(8'h20, 8'h00);
			wr(8'h00, ct[i] & 8'hC0);
			wr(8'h04, ct[i]);
			wr(8'h20, 8'h01);
			repeat (5) @(posedge clk);
			`CHK(pin_out, bf[i])
			`CHK(pin_oe, 3'h7)
			repeat (40) @(posedge clk);
			`CHK(pin_out, af[i])
		end
		$display("Output test done");
		wr(8'h20, 8'h00);
		wr(8'h00, 8'h40);
		for (int p = 0; p < 4; p++)
		begin
			wr(8'h04, 8'h40 | (p[7:0] << 4));
			wr(8'h20, 8'h01);
			repeat (10) @(posedge clk);
			cap(1'b1, re[p]);
			cap(1'b0, fe[p]);
		end
		$display("Capture test done");
		conclude;
	end
endmodule : enhanced_timer_chan_b_ctrl_tb

/* File: dv/etimer_chk.sv */
// Port checker for the timer channel B block.
// Assumes one clock and binding to etimer_chan_b.
module etimer_chk
	import etimer_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [2:0] chan_b_pin_out,
	input wire logic [2:0] chan_b_pin_oe,
	input wire chan_mode_t chan_a_mode_sel,
	input wire logic capture_seen
);
	import etimer_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence s_rd;
		hsel && htrans[1] && hready && !hwrite;
	endsequence
	sequence s_hi;
		haddr[31:5] == 27'h0 && haddr[2:0] == 3'h4 && haddr[4:3] != 2'h0;
	endsequence
	property p_hi_zero;
		s_rd ##0 s_hi |=> hrdata[31:2] == 30'h0;
	endproperty
	a_hi_zero: assert property (p_hi_zero) else $error("high bits set");
	property p_lo_zero;
		s_rd |=> hrdata[31:8] == 24'h0;
	endproperty
	a_lo_zero: assert property (p_lo_zero) else $error("wide read");
	property p_ready;
		hreadyout && !hresp;
	endproperty
	a_ready: assert property (p_ready) else $error("bus answer");
	property p_pins_same;
		chan_b_pin_out == {3{chan_b_pin_out[0]}};
	endproperty
	a_pins_same: assert property (p_pins_same) else $error("pins split");
	property p_oe_same;
		chan_b_pin_oe == {3{chan_b_pin_oe[0]}};
	endproperty
	a_oe_same: assert property (p_oe_same) else $error("enables split");
	property p_cap_pulse;
		capture_seen |=> !capture_seen;
	endproperty
	a_cap_pulse: assert property (p_cap_pulse) else $error("long pulse");
	property p_cap_idle;
		capture_seen |-> chan_b_pin_oe == 3'h0;
	endproperty
	a_cap_idle: assert property (p_cap_idle) else $error("capture drive");
	property p_rst_pins;
		$rose(resetn) |-> (chan_b_pin_oe == 3'h0 && chan_b_pin_out == 3'h0)[*3];
	endproperty
	a_rst_pins: assert property (p_rst_pins) else $error("pins at reset");
	property p_rst_mode;
		$rose(resetn) |-> (chan_a_mode_sel == MODE_COMPARE)[*3];
	endproperty
	a_rst_mode: assert property (p_rst_mode) else $error("mode at reset");
endmodule : etimer_chk
bind etimer_chan_b etimer_chk etimer_chk_inst (.clk(clk), .resetn(resetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.chan_b_pin_out(chan_b_pin_out), .chan_b_pin_oe(chan_b_pin_oe),
	.chan_a_mode_sel(chan_a_mode_sel), .capture_seen(capture_seen));

/* File: dv/pin_model.sv */
// Model of the three channel B pins outside the device.
// Assumes the bench sets the external level when pins are inputs.
module pin_model (
	input wire logic [2:0] pin_out,
	input wire logic [2:0] pin_oe,
	input wire logic lvl,
	output logic [2:0] pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// A driven pin reads back its own level, else the outside level.
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & {3{lvl}});
endmodule : pin_model

/* File: rtl/chan_b_pins.sv */
// Channel B pin logic: compare output, PWM, single pulse and capture edges.
// Assumes synchronised pin inputs and settings from the register block.
`include "etimer_defs.svh"
module chan_b_pins
	import etimer_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	chan_cfg_if.pins cfg,
	input wire logic [`PIN_COUNT-1:0] pin_in,
	output logic [`PIN_COUNT-1:0] pin_out,
	output logic capture_evt
);
	logic level_r;
	logic pulse_done_r;
	logic [`PIN_COUNT-1:0] prev_r;
	logic active;
	logic match_ok;

	// Match qualified by centre-alignment direction.
	always_comb
	begin
		unique case (cfg.align)
			2'h0: match_ok = cfg.match_b;
			2'h1: match_ok = cfg.match_b & cfg.count_up;
			2'h2: match_ok = cfg.match_b & ~cfg.count_up;
			2'h3: match_ok = cfg.match_b;
		endcase
	end

	// PWM active while counter is below the compare value for function 2; function 0 never, 1 always, 3 only before the first match.
	always_comb
	begin
		active = 1'b0;
		unique case (cfg.pin_function)
			2'h0: active = 1'b0;
			2'h1: active = 1'b1;
			2'h2: active = cfg.timer_on & ~level_r;
			2'h3: active = cfg.timer_on & ~level_r & ~pulse_done_r;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			pulse_done_r <= 1'b0;
		else if (cfg.on_rise)
			pulse_done_r <= 1'b0;
		else if (cfg.mode == MODE_PWM && match_ok)
			pulse_done_r <= 1'b1;
	end

	// Shared level: compare pin state or PWM phase marker.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			level_r <= 1'b0;
		else if (cfg.mode == MODE_COMPARE)
		begin
			if (cfg.on_rise)
				level_r <= cfg.level;
			else if (cfg.timer_on && match_ok)
			begin
				unique case (cfg.pin_function)
					2'h0: level_r <= level_r;
					2'h1: level_r <= 1'b0;
					2'h2: level_r <= 1'b1;
					2'h3: level_r <= ~level_r;
				endcase
			end
		end
		else if (cfg.mode == MODE_PWM)
		begin
			if (cfg.at_zero || cfg.on_rise)
				level_r <= 1'b0;
			else if (match_ok)
				level_r <= ~level_r;
		end
		else
			level_r <= 1'b0;
	end

	// One level drives all three pins together.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			pin_out <= '0;
		else
		begin
			unique case (cfg.mode)
				MODE_COMPARE: pin_out <= {`PIN_COUNT{level_r ^ cfg.invert}};
				MODE_PWM: pin_out <= {`PIN_COUNT{(active ~^ cfg.level) ^ cfg.invert}};
				MODE_CAPTURE: pin_out <= '0;
				MODE_TIMER: pin_out <= '0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			prev_r <= '0;
		else
			prev_r <= pin_in;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			capture_evt <= 1'b0;
		else if (cfg.mode != MODE_CAPTURE || !cfg.timer_on)
			capture_evt <= 1'b0;
		else
		begin
			unique case (cfg.pin_function)
				2'h0: capture_evt <= |(pin_in & ~prev_r);
				2'h1: capture_evt <= |(~pin_in & prev_r);
				2'h2: capture_evt <= |(pin_in ^ prev_r);
				2'h3: capture_evt <= 1'b0;
			endcase
		end
	end
endmodule : chan_b_pins

/* File: rtl/chan_cfg_if.sv */
// Interface carrying channel B settings and counter state to the pin logic.
// Assumes one clock shared by both ends.
interface chan_cfg_if;
	import etimer_pkg::*;
	chan_mode_t mode;
	logic [1:0] pin_function;
	logic level;
	logic invert;
	logic [1:0] align;
	logic timer_on;
	logic on_rise;
	logic count_up;
	logic match_b;
	logic at_zero;
	modport ctrl (output mode, pin_function, level, invert, align, timer_on,
		on_rise, count_up, match_b, at_zero);
	modport pins (input mode, pin_function, level, invert, align, timer_on,
		on_rise, count_up, match_b, at_zero);
endinterface : chan_cfg_if

/* File: rtl/etimer_chan_b.sv */
// Timer channel B with registers on AHB-Lite and three channel B pins.
// Assumes pins arrive asynchronous and the bus shares clk.
//
// Local design decisions: register access over AHB-Lite and the register offsets.
`include "etimer_defs.svh"
module etimer_chan_b
	import etimer_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [`PIN_COUNT-1:0] chan_b_pin_in,
	output logic [`PIN_COUNT-1:0] chan_b_pin_out,
	output logic [`PIN_COUNT-1:0] chan_b_pin_oe,
	output chan_mode_t chan_a_mode_sel,
	output logic capture_seen
);
	import etimer_pkg::*;

	logic rst_sync1_r;
	logic rst_n;
	logic [7:0] ctrl_a_r;
	logic [7:0] ctrl_b_r;
	logic [7:0] ctrl_t_r;
	count_t cmp_a_r;
	count_t cmp_b_r;
	count_t count_r;
	count_t capt_r;
	logic dir_down_r;
	logic ton_prev_r;
	logic wr_pend_r;
	logic [7:0] wr_addr_r;
	logic [7:0] rd_data;
	logic [`PIN_COUNT-1:0] s1_r;
	logic [`PIN_COUNT-1:0] s2_r;
	logic [`PIN_COUNT-1:0] s3_r;
	logic [`PIN_COUNT-1:0] pin_stable_r;
	logic capture_evt;
	logic [`PIN_COUNT-1:0] pin_drive;
	logic ton;
	logic on_rise;
	logic a_match;
	chan_mode_t b_mode;
	chan_cfg_if cfg ();

	function automatic logic [7:0] hi_bits(input count_t v);
		hi_bits = {6'h00, v[`CNT_WIDTH-1:8]};
	endfunction : hi_bits

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rst_sync1_r <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_sync1_r <= 1'b1;
			rst_n <= rst_sync1_r;
		end
	end

	assign ton = ctrl_t_r[`TON_BIT];
	assign on_rise = ton & ~ton_prev_r;
	assign b_mode = chan_mode_t'(ctrl_b_r[`MODE_HI:`MODE_LO]);
	assign a_match = (count_r == cmp_a_r);

	// Bus slave: zero wait states; writes land at the data phase.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
		end
		else if (hready)
		begin
			wr_pend_r <= hsel & htrans[1] & hwrite;
			wr_addr_r <= haddr[7:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_a_r <= `REG_RESET;
			ctrl_b_r <= `REG_RESET;
			ctrl_t_r <= `REG_RESET;
			cmp_a_r <= '0;
			cmp_b_r <= '0;
		end
		else if (wr_pend_r)
		begin
			unique case (wr_addr_r)
				`OFF_CTRL_A: ctrl_a_r <= hwdata[7:0];
				`OFF_CTRL_B: ctrl_b_r <= hwdata[7:0];
				`OFF_CTRL_T: ctrl_t_r <= {6'h00, hwdata[1:0]};
				`OFF_CMPA_LO: cmp_a_r[7:0] <= hwdata[7:0];
				`OFF_CMPA_HI: cmp_a_r[`CNT_WIDTH-1:8] <= hwdata[1:0];
				`OFF_CMPB_LO: cmp_b_r[7:0] <= hwdata[7:0];
				`OFF_CMPB_HI: cmp_b_r[`CNT_WIDTH-1:8] <= hwdata[1:0];
				default: ;
			endcase
		end
	end

	always_comb
	begin
		unique case (haddr[7:0])
			`OFF_CTRL_A: rd_data = ctrl_a_r;
			`OFF_CTRL_B: rd_data = ctrl_b_r;
			`OFF_CTRL_T: rd_data = ctrl_t_r;
			`OFF_CNT_LO: rd_data = count_r[7:0];
			`OFF_CNT_HI: rd_data = hi_bits(count_r);
			`OFF_CMPA_LO: rd_data = cmp_a_r[7:0];
			`OFF_CMPA_HI: rd_data = hi_bits(cmp_a_r);
			`OFF_CMPB_LO: rd_data = (b_mode == MODE_CAPTURE) ? capt_r[7:0] : cmp_b_r[7:0];
			`OFF_CMPB_HI: rd_data = hi_bits((b_mode == MODE_CAPTURE) ? capt_r : cmp_b_r);
			default: rd_data = 8'h00;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			hrdata <= 32'h00000000;
		else if (hready && hsel && htrans[1] && !hwrite)
			hrdata <= {24'h000000, rd_data};
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			ton_prev_r <= 1'b0;
		else
			ton_prev_r <= ton;
	end

	// Counter: clears on enable rise, holds while off, up/down in centre mode.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			count_r <= '0;
			dir_down_r <= 1'b0;
		end
		else if (on_rise)
		begin
			count_r <= '0;
			dir_down_r <= 1'b0;
		end
		else if (ton)
		begin
			if (b_mode == MODE_PWM && ctrl_b_r[`ALIGN_HI:`ALIGN_LO] != 2'h0)
			begin
				if (!dir_down_r && count_r == `CNT_MAX - 10'h001)
					dir_down_r <= 1'b1;
				else if (dir_down_r && count_r == 10'h001)
					dir_down_r <= 1'b0;
				count_r <= dir_down_r ? count_r - 10'h001 : count_r + 10'h001;
			end
			else if (ctrl_t_r[`CLR_SEL_BIT] && a_match)
				count_r <= '0;
			else
				count_r <= count_r + 10'h001;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			capt_r <= '0;
		else if (capture_evt)
			capt_r <= count_r;
	end

	// Three-stage pin synchroniser; accept once stages two and three agree.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			pin_stable_r <= '0;
		end
		else
		begin
			s1_r <= chan_b_pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			pin_stable_r <= pin_stable_r ^ ((s2_r ~^ s3_r) & (s3_r ^ pin_stable_r));
		end
	end

	assign cfg.mode = b_mode;
	assign cfg.pin_function = ctrl_b_r[`PINF_HI:`PINF_LO];
	assign cfg.level = ctrl_b_r[`LEVEL_BIT];
	assign cfg.invert = ctrl_b_r[`INV_BIT];
	assign cfg.align = ctrl_b_r[`ALIGN_HI:`ALIGN_LO];
	assign cfg.timer_on = ton;
	assign cfg.on_rise = on_rise;
	assign cfg.count_up = ~dir_down_r;
	assign cfg.match_b = ton & (count_r == cmp_b_r);
	assign cfg.at_zero = (count_r == '0);

	chan_b_pins u_pins (
		.clk(clk),
		.rst_n(rst_n),
		.cfg(cfg),
		.pin_in(pin_stable_r),
		.pin_out(pin_drive),
		.capture_evt(capture_evt)
	);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			chan_b_pin_out <= '0;
			chan_b_pin_oe <= '0;
			chan_a_mode_sel <= MODE_COMPARE;
			capture_seen <= 1'b0;
		end
		else
		begin
			chan_b_pin_out <= pin_drive;
			chan_b_pin_oe <= {`PIN_COUNT{b_mode == MODE_COMPARE || b_mode == MODE_PWM}};
			chan_a_mode_sel <= chan_mode_t'(ctrl_a_r[`MODE_HI:`MODE_LO]);
			capture_seen <= capture_evt;
		end
	end
endmodule : etimer_chan_b

/* File: rtl/etimer_defs.svh */
// Register offsets, field positions and reset values of the timer channel.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef ETIMER_DEFS_SVH
`define ETIMER_DEFS_SVH
`define OFF_CTRL_A 8'h00
`define OFF_CTRL_B 8'h04
`define OFF_CNT_LO 8'h08
`define OFF_CNT_HI 8'h0C
`define OFF_CMPA_LO 8'h10
`define OFF_CMPA_HI 8'h14
`define OFF_CMPB_LO 8'h18
`define OFF_CMPB_HI 8'h1C
`define OFF_CTRL_T 8'h20
`define MODE_HI 7
`define MODE_LO 6
`define PINF_HI 5
`define PINF_LO 4
`define LEVEL_BIT 3
`define INV_BIT 2
`define ALIGN_HI 1
`define ALIGN_LO 0
`define TON_BIT 0
`define CLR_SEL_BIT 1
`define REG_RESET 8'h00
`define CNT_WIDTH 10
`define CNT_MAX 10'h3FF
`define PIN_COUNT 3
`define SYNC_DEPTH 3
`endif

/* File: rtl/etimer_pkg.sv */
// Types shared by the timer channel modules.
// Assumes the definitions header sits beside it.
`include "etimer_defs.svh"
package etimer_pkg;
	typedef enum logic [1:0] {
		MODE_COMPARE = 2'h0,
		MODE_CAPTURE = 2'h1,
		MODE_PWM = 2'h2,
		MODE_TIMER = 2'h3
	} chan_mode_t;
	typedef logic [`CNT_WIDTH-1:0] count_t;
endpackage : etimer_pkg
